// ==== hw/rps_switchover.sv ====
// switchover logic of one amplifier in a redundant pair
// assumes power figures are from same-clock logic; pin levels are asynchronous
module rps_switchover
    import rps_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic automatic_switch_enable_i,
    input wire logic peer_summary_fault_indicator_i,
    input wire logic peer_transmit_indicator_i,
    input wire logic tellback_on_air_i,
    input wire logic self_transmit_state_i,
    input wire logic self_fault_i,
    input wire logic [PWR_W-1:0] self_power_mw_i,
    input wire logic [PWR_W-1:0] low_power_alarm_mw_i,
    output logic coil_drive_o,
    output logic self_low_power_o,
    output logic redundancy_fault_output_o,
    output logic auto_mode_o,
    output logic [3:0] state_o
);
    ////////////////////////////////////////////////////////////////////////
    // pin synchronisation
    // the four pins come from the peer, the switch and the operator side;
    // none is read before two flops have settled it
    rps_sync_if sif();
    logic ena_s;
    logic peer_flt_s;
    logic peer_tx_s;
    logic on_air_s;

    assign sif.raw = {tellback_on_air_i, peer_transmit_indicator_i,
                      peer_summary_fault_indicator_i, automatic_switch_enable_i};
    assign {on_air_s, peer_tx_s, peer_flt_s, ena_s} = sif.clean;

    rps_sync u_sync (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .s(sif.snk)
    );

    ////////////////////////////////////////////////////////////////////////
    // alarm threshold
    // an alarm set below the floor would let a dying unit keep the antenna
    logic [PWR_W-1:0] thr;
    logic thr_clamped;

    always_comb begin
        thr_clamped = (low_power_alarm_mw_i < MIN_PWR_MW);
        if (thr_clamped) begin
            thr = MIN_PWR_MW;
        end else begin
            thr = low_power_alarm_mw_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // own health
    logic self_ok;
    logic self_below;

    always_comb begin
        self_ok = self_transmit_state_i & ~self_fault_i;
        // low power only counts while transmitting; standby has no rf out
        self_below = self_transmit_state_i & (self_power_mw_i < thr);
    end

    ////////////////////////////////////////////////////////////////////////
    // peer health
    // peer low power arrives folded into its summary fault line
    logic peer_bad;
    logic peer_good;

    always_comb begin
        peer_bad = peer_flt_s | ~peer_tx_s;
        peer_good = ~peer_bad;
    end

    ////////////////////////////////////////////////////////////////////////
    // takeover decision
    // a unit already on air gains nothing from pulsing the coil
    // a sick unit must not grab the antenna from a sick peer either
    logic take_req;

    always_comb begin
        take_req = peer_bad & ~on_air_s & self_ok;
    end

    ////////////////////////////////////////////////////////////////////////
    // switchover state machine
    // fixed length coil pulse: the tell-back is not trusted to end it,
    // a stuck contact would otherwise keep the coil energised for good
    rps_state_t state_r;
    rps_state_t state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic coil_r;
    logic coil_nxt;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        coil_nxt = 1'b0;
        case (state_r)
            RPS_IDLE: begin
                if (ena_s) begin
                    state_nxt = RPS_ARMED;
                end
            end
            RPS_ARMED: begin
                if (!ena_s) begin
                    state_nxt = RPS_IDLE;
                end else if (take_req) begin
                    state_nxt = RPS_DRIVE;
                    cnt_nxt = CNT_W'(COIL_CYC - 1);
                    coil_nxt = 1'b1;
                end
                // both healthy: hold, no coil activity
            end
            RPS_DRIVE: begin
                // enable dropping mid pulse still finishes it; a half
                // moved switch is worse than a late one
                coil_nxt = 1'b1;
                if (cnt_r == '0) begin
                    coil_nxt = 1'b0;
                    state_nxt = RPS_LOCKED;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            RPS_LOCKED: begin
                // one shot: wait for the peer to recover before rearming
                if (!ena_s) begin
                    state_nxt = RPS_IDLE;
                end else if (peer_good) begin
                    state_nxt = RPS_ARMED;
                end
            end
            default: begin
                state_nxt = RPS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r <= RPS_IDLE;
            cnt_r <= '0;
            coil_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            coil_r <= coil_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status outputs, all registered
    logic low_r;
    logic low_nxt;
    logic rfo_r;
    logic rfo_nxt;
    logic auto_r;
    logic auto_nxt;

    always_comb begin
        low_nxt = self_below;
        // silent until the pair owns the switch
        rfo_nxt = ena_s & ~self_ok;
        // taken from the next state so it lines up with state_o
        auto_nxt = (state_nxt != RPS_IDLE);
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            low_r <= 1'b0;
            rfo_r <= 1'b0;
            auto_r <= 1'b0;
        end else begin
            low_r <= low_nxt;
            rfo_r <= rfo_nxt;
            auto_r <= auto_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // port assignments
    // every output is a flop; no logic between register and pin
    assign coil_drive_o = coil_r;
    assign self_low_power_o = low_r;
    assign redundancy_fault_output_o = rfo_r;
    assign auto_mode_o = auto_r;
    assign state_o = state_r;
endmodule

// ==== hw/rps_pkg.sv ====
// constants and types for the redundant pair switchover block
// assumes one 250 MHz clock; rps_switchover brings the pins into this domain itself
// Operation
// - with automatic enable asserted the amplifiers own the waveguide switch.
// - both healthy and above threshold power: switch position stays unchanged.
// - each amplifier keeps watching the peer fault and transmit status.
// - routed unit faults or drops below alarm level: the other takes the switch.
// - low power alarm threshold is clamped to the minimum output power.
// - after a switchover both units stay in automatic mode unprompted.
// - with first faulty unit unrecovered, a second fault never drives the switch.
// - tell-back contact says which unit is on air; drive the 24 V coil.
// - redundancy fault output stays off without the automatic enable.
package rps_pkg;
    localparam int PWR_W = 16;
    // power in milliwatts
    localparam logic [PWR_W-1:0] MIN_PWR_MW = 16'h03e8;
    localparam int CLK_MHZ = 250;
    // coil pulse length, long enough for a typical mechanical switch
    localparam int COIL_PULSE_MS = 150;
    localparam int COIL_CYC = COIL_PULSE_MS * 1000 * CLK_MHZ;
    localparam int CNT_W = 26;
    localparam int SYNC_W = 4;
    typedef enum logic [3:0] {
        RPS_IDLE = 4'h1,
        RPS_ARMED = 4'h2,
        RPS_DRIVE = 4'h4,
        RPS_LOCKED = 4'h8
    } rps_state_t;
endpackage

// ==== hw/rps_sync_if.sv ====
// carries raw pin levels into the synchroniser and clean levels out of it
// assumes one clock domain on the consumer side
interface rps_sync_if;
    logic [3:0] raw;
    logic [3:0] clean;
    modport src (output raw, input clean);
    modport snk (input raw, output clean);
endinterface

// ==== hw/rps_sync.sv ====
// two-flop synchroniser for the loose pin inputs, one per bit
// assumes inputs arrive asynchronously to clk_sys_i
module rps_sync
    import rps_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    rps_sync_if.snk s
);
    genvar g;
    generate
        for (g = 0; g < SYNC_W; g++) begin : g_bit
            logic meta_r;
            logic hold_r;
            always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    meta_r <= 1'b0;
                    hold_r <= 1'b0;
                end else begin
                    meta_r <= s.raw[g];
                    hold_r <= meta_r;
                end
            end
            assign s.clean[g] = hold_r;
        end
    endgenerate
endmodule

// ==== sim/rps_switchover_assertions.sv ====
// checker for one amplifier's switchover logic
// assumes the top ports only, one clock, async low reset
module rps_switchover_assertions
    import rps_pkg::*;
(
    input wire logic clk_sys_i, arst_n_i, automatic_switch_enable_i,
    input wire logic peer_summary_fault_indicator_i, peer_transmit_indicator_i,
    input wire logic tellback_on_air_i, self_transmit_state_i, self_fault_i,
    input wire logic [PWR_W-1:0] self_power_mw_i, low_power_alarm_mw_i,
    input wire logic coil_drive_o, self_low_power_o, redundancy_fault_output_o,
    input wire logic auto_mode_o,
    input wire logic [3:0] state_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);
    // alarm level never below the minimum power
    wire logic [PWR_W-1:0] thr_w =
        (low_power_alarm_mw_i < MIN_PWR_MW) ? MIN_PWR_MW : low_power_alarm_mw_i;
    wire logic low_w = self_transmit_state_i && (self_power_mw_i < thr_w);
    AST_RFO_CAUSE: assert property (redundancy_fault_output_o |->
        auto_mode_o && $past(!self_transmit_state_i || self_fault_i)) else $error("rfo");
    AST_LOW_PWR: assert property ($past(arst_n_i) |->
        self_low_power_o == $past(low_w)) else $error("low power");
    AST_COIL_SELF: assert property ($rose(coil_drive_o) |->
        $past(self_transmit_state_i && !self_fault_i) && $past(state_o) == 4'h2)
        else $error("coil cause");
    AST_DRIVE_COIL: assert property (coil_drive_o == (state_o == 4'h4))
        else $error("coil state");
    AST_LOCK_EXIT: assert property ($past(state_o) == 4'h8 |-> state_o != 4'h4)
        else $error("relock");
    AST_HOLD: assert property ((peer_transmit_indicator_i &&
        !peer_summary_fault_indicator_i) [*5] |-> !$rose(coil_drive_o)) else $error("hold");
    AST_TAKEOVER: assert property ((state_o == 4'h2 && self_transmit_state_i &&
        !self_fault_i && !tellback_on_air_i && peer_summary_fault_indicator_i) [*4]
        |-> ##[0:2] coil_drive_o) else $error("takeover");
    AST_ENA_ARM: assert property (automatic_switch_enable_i [*5] |-> auto_mode_o)
        else $error("arm");
    cover property ($rose(coil_drive_o));
    cover property (redundancy_fault_output_o);
    cover property (self_low_power_o);
endmodule
bind rps_switchover rps_switchover_assertions i_chk (.clk_sys_i, .arst_n_i,
    .automatic_switch_enable_i, .peer_summary_fault_indicator_i, .peer_transmit_indicator_i,
    .tellback_on_air_i, .self_transmit_state_i, .self_fault_i, .self_power_mw_i,
    .low_power_alarm_mw_i, .coil_drive_o, .self_low_power_o, .redundancy_fault_output_o,
    .auto_mode_o, .state_o);

// ==== sim/rps_peer_model.sv ====
// peer amplifier status lines and the waveguide switch
// assumes the bench commands peer health and the preset position
module rps_peer_model #(
    parameter int SW_CYC = 20
) (
    input wire logic clk_sys_i,
    input wire logic coil_i,
    input wire logic preset_i,
    input wire logic fault_i,
    input wire logic tx_i,
    output logic sum_fault_o,
    output logic transmit_o,
    output logic on_air_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    initial on_air_o = 1'b0;
    // switch moves part-way into the pulse, as a real actuator does
    always @(posedge clk_sys_i) begin
        cnt <= coil_i ? cnt + 1 : 0;
        if (cnt == SW_CYC) begin
            on_air_o <= 1'b1;
        end else if (!coil_i) begin
            on_air_o <= preset_i;
        end
    end
    assign sum_fault_o = fault_i;
    assign transmit_o = tx_i;
endmodule

// ==== sim/tb_top.sv ====
// self-checking bench for one amplifier's switchover logic
// assumes the peer model stands in for partner unit and switch
module tb_top
    import rps_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic tx, flt; logic [PWR_W-1:0] pwr, thr; logic low, rfo;} rps_row_t;
    logic clk_sys_i = 1'b0, arst_n_i = 1'b0, automatic_switch_enable_i = 1'b0;
    logic self_transmit_state_i = 1'b0, self_fault_i = 1'b0;
    logic preset = 1'b0, pflt = 1'b0, ptx = 1'b1;
    logic [PWR_W-1:0] self_power_mw_i = 16'h0000, low_power_alarm_mw_i = 16'h0000;
    logic peer_summary_fault_indicator_i, peer_transmit_indicator_i, tellback_on_air_i;
    logic coil_drive_o, self_low_power_o, redundancy_fault_output_o, auto_mode_o;
    logic [3:0] state_o;
    int err_count = 0, n_compared = 0;
    rps_row_t rows[6] = '{'{1, 0, 16'h05dc, 16'h07d0, 1, 0}, '{1, 0, 16'h05dc, 16'h03e8, 0, 0},
        '{1, 0, 16'h03e7, 16'h0005, 1, 0}, '{1, 0, 16'h03e8, 16'h0000, 0, 0},
        '{1, 1, 16'h1388, 16'h03e8, 0, 1}, '{0, 0, 16'h0000, 16'h0000, 0, 1}};
    rps_switchover i_dut (.clk_sys_i, .arst_n_i, .automatic_switch_enable_i,
        .peer_summary_fault_indicator_i, .peer_transmit_indicator_i, .tellback_on_air_i,
        .self_transmit_state_i, .self_fault_i, .self_power_mw_i, .low_power_alarm_mw_i,
        .coil_drive_o, .self_low_power_o, .redundancy_fault_output_o, .auto_mode_o, .state_o);
    rps_peer_model i_peer (.clk_sys_i, .coil_i(coil_drive_o), .preset_i(preset),
        .fault_i(pflt), .tx_i(ptx), .sum_fault_o(peer_summary_fault_indicator_i),
        .transmit_o(peer_transmit_indicator_i), .on_air_o(tellback_on_air_i));
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic summarize;
        $display("compared %0d errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial forever #2 clk_sys_i = ~clk_sys_i;
    // budget is 2500 cycles, far above the roughly 100 cycles of tests
    initial begin
        #10000;
        err_count++;
        summarize();
    end
    initial begin
        step(4);
        chk("state", 4'h1, state_o);
        arst_n_i = 1'b1;
        step(8);
        chk("rfo", 1'b0, redundancy_fault_output_o);
        {preset, self_transmit_state_i, automatic_switch_enable_i} = 3'h7;
        step(6);
        chk("auto", 1'b1, auto_mode_o);
        foreach (rows[i]) begin
            {self_transmit_state_i, self_fault_i} = {rows[i].tx, rows[i].flt};
            {self_power_mw_i, low_power_alarm_mw_i} = {rows[i].pwr, rows[i].thr};
            step(2);
            chk("low", rows[i].low, self_low_power_o);
            chk("rfo", rows[i].rfo, redundancy_fault_output_o);
        end
        {self_transmit_state_i, self_fault_i} = 2'h2;
        step(10);
        chk("coil", 1'b0, coil_drive_o);
        pflt = 1'b1;
        step(10);
        chk("coil", 1'b0, coil_drive_o);
        {preset, self_fault_i} = 2'h1;
        step(10);
        chk("coil", 1'b0, coil_drive_o);
        self_fault_i = 1'b0;
        for (int i = 0; i < 10 && coil_drive_o !== 1'b1; i++) step(1);
        chk("state", 4'h4, state_o);
        step(30);
        chk("auto", 1'b1, auto_mode_o);
        chk("coil", 1'b1, coil_drive_o);
        summarize();
    end
endmodule
